// File: design/pbd_pkg.sv
// shared constants for the pattern tester with dual loopback
package pbd_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PCFG   = 8'h04;
  localparam logic [7:0] ADDR_SEED   = 8'h08;
  localparam logic [7:0] ADDR_CMD    = 8'h0C;
  localparam logic [7:0] ADDR_STAT   = 8'h10;
  localparam logic [7:0] ADDR_LATCH  = 8'h14;
  localparam logic [7:0] ADDR_IEN    = 8'h18;
  localparam logic [7:0] ADDR_BITCNT = 8'h1C;
  localparam logic [7:0] ADDR_ERRCNT = 8'h20;
  // tester_control_reg fields
  localparam int CTRL_EN_BIT       = 0;
  localparam int CTRL_NORESYNC_BIT = 1;
  localparam int CTRL_PINSRC_BIT   = 2;
  localparam int CTRL_RATE_LSB     = 3;
  localparam int CTRL_W2C_BIT      = 6;
  localparam int CTRL_DLB_BIT      = 8;
  localparam int CTRL_RLB_BIT      = 9;
  localparam logic [9:0] CTRL_MASK = 10'h37F;
  // pattern_config_reg fields
  localparam int PCFG_LEN_LSB   = 0;
  localparam int PCFG_PTS_BIT   = 5;
  localparam int PCFG_QRSS_BIT  = 6;
  localparam int PCFG_TAP_LSB   = 8;
  localparam int PCFG_TXINV_BIT = 14;
  localparam int PCFG_RXINV_BIT = 15;
  localparam logic [15:0] PCFG_MASK = 16'hDF7F;
  // tester_command_reg fields
  localparam int CMD_TXLOAD_BIT = 0;
  localparam int CMD_RXLOAD_BIT = 1;
  localparam int CMD_UPDATE_BIT = 2;
  localparam int CMD_ERRINS_BIT = 3;
  // status and latched status fields
  localparam int ST_PMS_BIT = 0;
  localparam int ST_BE_BIT  = 1;
  localparam int ST_BEC_BIT = 2;
  localparam int ST_OOS_BIT = 3;
  // reset values
  localparam logic [9:0]  CTRL_RST = 10'h000;
  localparam logic [15:0] PCFG_RST = 16'h0000;
  localparam logic [31:0] SEED_RST = 32'hFFFFFFFF;
  localparam logic [3:0]  IEN_RST  = 4'h0;
  // synchroniser and monitor figures
  localparam logic [4:0] SYNC_LAST   = 5'h1F;
  localparam logic [5:0] WIN_LAST    = 6'h3F;
  localparam logic [2:0] LOSS_ERRS   = 3'h6;
  localparam int         QRSS_TAP_A  = 17;
  localparam int         QRSS_TAP_B  = 20;
  localparam int         QRSS_ZEROS  = 14;
  typedef enum logic [1:0] {SEARCH, VERIFY, INSYNC, HOLD} pbd_sync_type;
  // terminal count for one error per 10^n bits
  function automatic logic [23:0] pbd_rate_limit(input logic [2:0] rate);
    case (rate)
      3'h1:    pbd_rate_limit = 24'h000009;
      3'h2:    pbd_rate_limit = 24'h000063;
      3'h3:    pbd_rate_limit = 24'h0003E7;
      3'h4:    pbd_rate_limit = 24'h00270F;
      3'h5:    pbd_rate_limit = 24'h01869F;
      3'h6:    pbd_rate_limit = 24'h0F423F;
      default: pbd_rate_limit = 24'h98967F;
    endcase
  endfunction
endpackage

// File: design/pbd_bert.sv
// pattern tester with error insertion, sync monitor and loopback select
//
// Overview of operation
// - both loopbacks on: tx system pins go to rx outputs, line in to out.
// - pseudorandom generator x^n+x^y+1, n 1..32, y 1..n-1, any seed.
// - repetitive mode sends and detects a 1..32 bit user pattern.
// - tester runs only while its enable bit is one.
// - host raises load bits; generator loads pattern on the rising edge.
// - count-nonzero status is one exactly while error counter is nonzero.
// - 24-bit error, 32-bit bit counters copied then cleared on update.
// - six errors within 64 bits drop sync and raise out-of-sync.
// - status changes set latched bits; enabled bits pull irq_n low.
// - latched bits clear on read, or by writing one when selected.
// - 32-bit generators shift toward bit 32, feedback into bit 1.
// - quasi-random uses bits 17^20, output one after fourteen zeros.
// - pseudorandom feedback forced to one when bits 1..31 are zero.
// - pseudorandom sync loads 32 bits, then needs 32 matching bits.
// - repetitive sync finds pattern at any position, then 32 matches.
// - loss of sync restarts search unless auto resync is disabled.
// - out-of-sync outside sync state; counters frozen meanwhile.
// - mismatch counts error and bit, match counts bit only.
// - new load presets transmit generator before output begins.
// - errors inserted once per 10^n bits, n 1..7, or none.
// - single error from register command or pin change, by select.
// - inversion applied to the test stream before overhead.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
module pbd_bert
  import pbd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        txPosData,
  input  wire logic        txNegData,
  input  wire logic        txSysClock,
  input  wire logic        lineRxA,
  input  wire logic        lineRxB,
  input  wire logic        manualErrorInsertIn,
  output logic             rxPosData,
  output logic             rxNegData,
  output logic             rxSysClock,
  output logic             lineTxA,
  output logic             lineTxB,
  output logic             irq_n
);
  localparam int NPIN = 6;
  logic [9:0]   ctrl_q;
  logic [15:0]  pcfg_q;
  logic [31:0]  seed_q;
  logic [2:0]   cmd_q;
  logic [2:0]   cmdPrev_q;
  logic [3:0]   ien_q;
  logic [3:0]   latched_q;
  logic [31:0]  bitCountReg_q;
  logic [23:0]  errCountReg_q;
  logic         aphValid_q;
  logic         aphWrite_q;
  logic [7:0]   aphAddr_q;
  logic [31:0]  hrdata_q;
  logic         irqN_q;
  logic [NPIN-1:0] pinS1_q, pinS2_q, pinS3_q;
  logic         pinStable_q, pinPrev_q;
  logic         lineTxA_q, lineTxB_q, rxPos_q, rxNeg_q, rxClk_q;
  logic [31:0]  txGen_q;
  logic         txErrPend_q;
  logic [23:0]  rateCnt_q;
  logic         bertTx_q;
  pbd_sync_type state_q;
  logic [31:0]  rxGen_q;
  logic [31:0]  hist_q;
  logic [31:0]  rxPattern_q;
  logic [4:0]   syncCnt_q;
  logic [5:0]   winCnt_q;
  logic [2:0]   winErr_q;
  logic [31:0]  bitCnt_q;
  logic [23:0]  errCnt_q;
  logic         statPms_q, statBe_q, becPrev_q, oosPrev_q;

  // ---------------- bus slave ----------------
  logic aphTake;
  logic rdLatch, enable, rep, qrss, w2c;
  logic [4:0] lenF, tapF;
  logic [3:0] status, setEv, clrEv;
  logic txLoad, rxLoad, pmUpdate, regErrIns;

  assign aphTake   = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign enable    = ctrl_q[CTRL_EN_BIT];
  assign w2c       = ctrl_q[CTRL_W2C_BIT];
  assign lenF      = pcfg_q[PCFG_LEN_LSB +: 5];
  assign tapF      = pcfg_q[PCFG_TAP_LSB +: 5];
  assign rep       = pcfg_q[PCFG_PTS_BIT];
  assign qrss      = pcfg_q[PCFG_QRSS_BIT];
  assign rdLatch   = aphTake && !hwrite && haddr[7:0] == ADDR_LATCH;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      aphValid_q <= 1'b0;
      aphWrite_q <= 1'b0;
      aphAddr_q  <= 8'h00;
      hrdata_q   <= 32'h00000000;
    end
    else
    begin
      aphValid_q <= aphTake;
      aphWrite_q <= hwrite;
      aphAddr_q  <= haddr[7:0];
      if (aphTake && !hwrite)
      begin
        case (haddr[7:0])
          ADDR_CTRL:   hrdata_q <= {22'h000000, ctrl_q};
          ADDR_PCFG:   hrdata_q <= {16'h0000, pcfg_q};
          ADDR_SEED:   hrdata_q <= seed_q;
          ADDR_CMD:    hrdata_q <= {29'h00000000, cmd_q};
          ADDR_STAT:   hrdata_q <= {28'h0000000, status};
          ADDR_LATCH:  hrdata_q <= {28'h0000000, latched_q};
          ADDR_IEN:    hrdata_q <= {28'h0000000, ien_q};
          ADDR_BITCNT: hrdata_q <= bitCountReg_q;
          ADDR_ERRCNT: hrdata_q <= {8'h00, errCountReg_q};
          default:     hrdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  logic wrEn;
  assign wrEn = aphValid_q && aphWrite_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RST;
      pcfg_q <= PCFG_RST;
      seed_q <= SEED_RST;
      ien_q  <= IEN_RST;
      cmd_q  <= 3'h0;
    end
    else if (wrEn)
    begin
      case (aphAddr_q)
        ADDR_CTRL: ctrl_q <= hwdata[9:0] & CTRL_MASK;
        ADDR_PCFG: pcfg_q <= hwdata[15:0] & PCFG_MASK;
        ADDR_SEED: seed_q <= hwdata;
        ADDR_CMD:  cmd_q  <= hwdata[2:0];
        ADDR_IEN:  ien_q  <= hwdata[3:0];
        default:   ;
      endcase
    end
  end

  // load and update command bits act on their 0-to-1 transition; error insert on each write with its bit set
  always_ff @(posedge clock)
  begin
    if (rst)
      cmdPrev_q <= 3'h0;
    else
      cmdPrev_q <= cmd_q;
  end
  assign txLoad    = cmd_q[CMD_TXLOAD_BIT] && !cmdPrev_q[CMD_TXLOAD_BIT];
  assign rxLoad    = cmd_q[CMD_RXLOAD_BIT] && !cmdPrev_q[CMD_RXLOAD_BIT];
  assign pmUpdate  = cmd_q[CMD_UPDATE_BIT] && !cmdPrev_q[CMD_UPDATE_BIT];
  assign regErrIns = wrEn && aphAddr_q == ADDR_CMD && hwdata[CMD_ERRINS_BIT];

  // ---------------- pin synchronisers ----------------
  logic [NPIN-1:0] pinIn;
  assign pinIn = {manualErrorInsertIn, txSysClock, txNegData, txPosData,
                  lineRxB, lineRxA};
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : gSync
      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          pinS1_q[gi] <= 1'b0;
          pinS2_q[gi] <= 1'b0;
          pinS3_q[gi] <= 1'b0;
        end
        else
        begin
          pinS1_q[gi] <= pinIn[gi];
          pinS2_q[gi] <= pinS1_q[gi];
          pinS3_q[gi] <= pinS2_q[gi];
        end
      end
    end
  endgenerate

  // only the slow error pin waits for two agreeing samples; the rails carry
  // one bit per cycle, so that filter would swallow every isolated bit
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pinStable_q <= 1'b0;
      pinPrev_q   <= 1'b0;
    end
    else
    begin
      if (pinS2_q[5] == pinS3_q[5])
        pinStable_q <= pinS3_q[5];
      pinPrev_q <= pinStable_q;
    end
  end
  logic sRxA, sRxB, sTxP, sTxN, sTxC, pinErrIns;
  assign {sTxC, sTxN, sTxP, sRxB, sRxA} = pinS3_q[4:0];
  assign pinErrIns = pinStable_q != pinPrev_q;

  // ---------------- generators ----------------
  function automatic logic genFb(input logic [31:0] g, input logic [4:0] n,
                                 input logic [4:0] y, input logic rp,
                                 input logic qr);
    logic fb;
    fb = 1'b0;
    if (rp)
      fb = g[n];
    else
    begin
      fb = qr ? (g[QRSS_TAP_A-1] ^ g[QRSS_TAP_B-1]) : (g[n] ^ g[y]);
      if (g[30:0] == 31'h00000000)
        fb = 1'b1;
    end
    return fb;
  endfunction

  function automatic logic genOut(input logic [31:0] g, input logic fb,
                                  input logic rp, input logic qr);
    return (!rp && qr && g[QRSS_ZEROS-1:0] == 14'h0000) ? 1'b1 : fb;
  endfunction

  logic txFb, txOut, rateHit, txBit;
  assign txFb    = genFb(txGen_q, lenF, tapF, rep, qrss);
  assign txOut   = genOut(txGen_q, txFb, rep, qrss);
  assign rateHit = ctrl_q[CTRL_RATE_LSB +: 3] != 3'h0
                   && rateCnt_q == pbd_rate_limit(ctrl_q[CTRL_RATE_LSB +: 3]);
  assign txBit   = txOut ^ (rateHit | txErrPend_q)
                   ^ pcfg_q[PCFG_TXINV_BIT];

  always_ff @(posedge clock)
  begin
    if (rst)
      txGen_q <= 32'h00000000;
    else if (txLoad)
      txGen_q <= seed_q;
    else if (enable)
      txGen_q <= {txGen_q[30:0], txFb};
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      rateCnt_q <= 24'h000000;
    else if (!enable || rateHit || ctrl_q[CTRL_RATE_LSB +: 3] == 3'h0)
      rateCnt_q <= 24'h000000;
    else
      rateCnt_q <= rateCnt_q + 24'h000001;
  end

  logic singleReq;
  assign singleReq = ctrl_q[CTRL_PINSRC_BIT] ? pinErrIns : regErrIns;
  always_ff @(posedge clock)
  begin
    if (rst)
      txErrPend_q <= 1'b0;
    else
      txErrPend_q <= singleReq || (txErrPend_q && !enable);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      bertTx_q <= 1'b0;
    else
      bertTx_q <= txBit;
  end

  // ---------------- receive sync ----------------
  logic rxBit, rxFb, rxOut, mismatch, inSync, lossEvent, countInc;
  logic [31:0] histNext, mask;
  assign rxBit     = sRxA ^ pcfg_q[PCFG_RXINV_BIT];
  assign rxFb      = genFb(rxGen_q, lenF, tapF, rep, qrss);
  assign rxOut     = genOut(rxGen_q, rxFb, rep, qrss);
  assign mismatch  = rxBit != rxOut;
  assign inSync    = state_q == INSYNC;
  assign countInc  = enable && inSync;
  assign lossEvent = countInc && mismatch && winErr_q == LOSS_ERRS - 3'h1;
  assign histNext  = {hist_q[30:0], rxBit};
  assign mask      = 32'hFFFFFFFF >> (5'h1F - lenF);

  always_ff @(posedge clock)
  begin
    if (rst)
      hist_q <= 32'h00000000;
    else if (enable)
      hist_q <= histNext;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q     <= SEARCH;
      rxGen_q     <= 32'h00000000;
      rxPattern_q <= 32'h00000000;
      syncCnt_q   <= 5'h00;
    end
    else if (rxLoad)
    begin
      state_q     <= SEARCH;
      rxGen_q     <= seed_q;
      rxPattern_q <= seed_q;
      syncCnt_q   <= 5'h00;
    end
    else if (enable)
    begin
      case (state_q)
        SEARCH:
          if (rep)
          begin
            if ((histNext & mask) == (rxPattern_q & mask))
            begin
              rxGen_q   <= histNext;
              syncCnt_q <= 5'h00;
              state_q   <= VERIFY;
            end
          end
          else
          begin
            rxGen_q   <= {rxGen_q[30:0], rxBit};
            syncCnt_q <= syncCnt_q + 5'h01;
            if (syncCnt_q == SYNC_LAST)
              state_q <= VERIFY;
          end
        VERIFY:
        begin
          rxGen_q   <= {rxGen_q[30:0], rxFb};
          syncCnt_q <= syncCnt_q + 5'h01;
          if (mismatch)
          begin
            state_q   <= SEARCH;
            syncCnt_q <= 5'h00;
          end
          else if (syncCnt_q == SYNC_LAST)
            state_q <= INSYNC;
        end
        INSYNC:
        begin
          rxGen_q <= {rxGen_q[30:0], rxFb};
          if (lossEvent)
          begin
            syncCnt_q <= 5'h00;
            state_q   <= ctrl_q[CTRL_NORESYNC_BIT] ? HOLD : SEARCH;
          end
        end
        HOLD:    state_q <= HOLD;
        default: state_q <= SEARCH;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst || !countInc)
    begin
      winCnt_q <= 6'h00;
      winErr_q <= 3'h0;
    end
    else
    begin
      winCnt_q <= winCnt_q + 6'h01;
      if (winCnt_q == WIN_LAST)
        winErr_q <= 3'h0;
      else if (mismatch)
        winErr_q <= winErr_q + 3'h1;
    end
  end

  // ---------------- counters ----------------
  logic [31:0] bitInc;
  logic [23:0] errInc;
  assign bitInc = {31'h00000000, countInc};
  assign errInc = {23'h000000, countInc && mismatch};

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bitCnt_q      <= 32'h00000000;
      errCnt_q      <= 24'h000000;
      bitCountReg_q <= 32'h00000000;
      errCountReg_q <= 24'h000000;
    end
    else if (pmUpdate)
    begin
      bitCountReg_q <= bitCnt_q;
      errCountReg_q <= errCnt_q;
      bitCnt_q      <= bitInc;
      errCnt_q      <= errInc;
    end
    else
    begin
      bitCnt_q <= bitCnt_q + bitInc;
      errCnt_q <= errCnt_q + errInc;
    end
  end

  // ---------------- status and interrupt ----------------
  assign status[ST_PMS_BIT] = statPms_q;
  assign status[ST_BE_BIT]  = statBe_q;
  assign status[ST_BEC_BIT] = errCnt_q != 24'h000000;
  assign status[ST_OOS_BIT] = !inSync;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      statPms_q <= 1'b0;
      statBe_q  <= 1'b0;
      becPrev_q <= 1'b0;
      oosPrev_q <= 1'b1;
    end
    else
    begin
      statPms_q <= pmUpdate;
      statBe_q  <= countInc && mismatch;
      becPrev_q <= status[ST_BEC_BIT];
      oosPrev_q <= status[ST_OOS_BIT];
    end
  end

  assign setEv[ST_PMS_BIT] = pmUpdate;
  assign setEv[ST_BE_BIT]  = countInc && mismatch;
  assign setEv[ST_BEC_BIT] = status[ST_BEC_BIT] != becPrev_q;
  assign setEv[ST_OOS_BIT] = status[ST_OOS_BIT] != oosPrev_q;
  assign clrEv = (rdLatch && !w2c) ? 4'hF :
                 (wrEn && w2c && aphAddr_q == ADDR_LATCH) ? hwdata[3:0] :
                 4'h0;

  always_ff @(posedge clock)
  begin
    if (rst)
      latched_q <= 4'h0;
    else
      latched_q <= (latched_q & ~clrEv) | setEv;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      irqN_q <= 1'b1;
    else
      irqN_q <= ~|(latched_q & ien_q);
  end
  assign irq_n = irqN_q;

  // ---------------- loopback routing ----------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lineTxA_q <= 1'b0;
      lineTxB_q <= 1'b0;
      rxPos_q   <= 1'b0;
      rxNeg_q   <= 1'b0;
      rxClk_q   <= 1'b0;
    end
    else
    begin
      if (ctrl_q[CTRL_RLB_BIT])
      begin
        lineTxA_q <= sRxA;
        lineTxB_q <= sRxB;
      end
      else
      begin
        lineTxA_q <= enable ? bertTx_q : sTxP;
        lineTxB_q <= enable ? 1'b0 : sTxN;
      end
      if (ctrl_q[CTRL_DLB_BIT])
      begin
        rxPos_q <= sTxP;
        rxNeg_q <= sTxN;
        rxClk_q <= sTxC;
      end
      else
      begin
        rxPos_q <= sRxA;
        rxNeg_q <= sRxB;
        rxClk_q <= !rxClk_q;
      end
    end
  end
  assign lineTxA    = lineTxA_q;
  assign lineTxB    = lineTxB_q;
  assign rxPosData  = rxPos_q;
  assign rxNegData  = rxNeg_q;
  assign rxSysClock = rxClk_q;

  // ---------------- assertions ----------------
  sequence sVerifyDone;
    enable && !rxLoad && state_q == VERIFY && syncCnt_q == SYNC_LAST
      && !mismatch;
  endsequence

  AST_SYNC_ENTRY: assert property (@(posedge clock) disable iff (rst)
    sVerifyDone |=> inSync)
    else $error("sync not declared after 32 matches");
  AST_COUNT_NZ: assert property (@(posedge clock) disable iff (rst)
    (aphTake && !hwrite && haddr[7:0] == ADDR_STAT)
      |=> hrdata[ST_BEC_BIT] == ($past(errCnt_q) != 24'h000000))
    else $error("count nonzero flag wrong");
  AST_FREEZE: assert property (@(posedge clock) disable iff (rst)
    (!inSync && !pmUpdate) |=> $stable(bitCnt_q) && $stable(errCnt_q))
    else $error("counter moved while out of sync");
  AST_BITCOUNT: assert property (@(posedge clock) disable iff (rst)
    (countInc && !pmUpdate) |=> bitCnt_q == $past(bitCnt_q) + 32'h1)
    else $error("bit count did not advance");
  AST_UPDATE: assert property (@(posedge clock) disable iff (rst)
    pmUpdate |=> bitCountReg_q == $past(bitCnt_q) && bitCnt_q <= 32'h1)
    else $error("monitor update did not copy and clear");
  AST_TXLOAD: assert property (@(posedge clock) disable iff (rst)
    txLoad |=> txGen_q == $past(seed_q))
    else $error("transmit generator not preset");
  AST_LOSS: assert property (@(posedge clock) disable iff (rst)
    (lossEvent && !rxLoad) |=> status[ST_OOS_BIT] ##1 latched_q[ST_OOS_BIT])
    else $error("sync not dropped on six errors");
  AST_IRQ: assert property (@(posedge clock) disable iff (rst)
    (|(latched_q & ien_q)) |=> !irq_n)
    else $error("interrupt not raised");
  AST_RDCLR: assert property (@(posedge clock) disable iff (rst)
    (rdLatch && !w2c && setEv == 4'h0) |=> latched_q == 4'h0 ##1 irq_n)
    else $error("read did not clear latched status");
  AST_DISABLED: assert property (@(posedge clock) disable iff (rst)
    (!enable && !txLoad) |=> $stable(txGen_q))
    else $error("generator ran while disabled");
  AST_DUAL: assert property (@(posedge clock) disable iff (rst)
    (ctrl_q[CTRL_RLB_BIT] && ctrl_q[CTRL_DLB_BIT])
      |=> lineTxA == $past(sRxA) && rxPosData == $past(sTxP))
    else $error("dual loopback routing wrong");
endmodule // pbd_bert

// File: sim/pbd_line_model.sv
// line partner: carries the transmit rails back to the receive rails
module pbd_line_model (
  input  wire logic clock,
  input  wire logic lineTxA,
  input  wire logic lineTxB,
  output logic      lineRxA,
  output logic      lineRxB
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    lineRxA = 1'h0;
    lineRxB = 1'h1;
  end
  // one bit of cable delay; the second rail comes back inverted
  always @(posedge clock)
  begin
    lineRxA <= lineTxA;
    lineRxB <= ~lineTxB;
  end
endmodule // pbd_line_model

// File: sim/tb_top.sv
// self-checking bench for the pattern tester
module tb_top;
  import pbd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        clock = 1'h0;
  logic        rst = 1'h1;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        txPosData = 1'h0;
  logic        txNegData = 1'h0;
  logic        manualErrorInsertIn = 1'h0;
  logic        txSysClock = 1'h0;
  logic        lineRxA;
  logic        lineRxB;
  logic        rxPosData;
  logic        rxNegData;
  logic        rxSysClock;
  logic        lineTxA;
  logic        lineTxB;
  logic        irq_n;
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;

  always #12.5 clock = ~clock;

  pbd_bert dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
    .txPosData(txPosData), .txNegData(txNegData), .txSysClock(txSysClock),
    .lineRxA(lineRxA), .lineRxB(lineRxB),
    .manualErrorInsertIn(manualErrorInsertIn), .rxPosData(rxPosData),
    .rxNegData(rxNegData), .rxSysClock(rxSysClock), .lineTxA(lineTxA),
    .lineTxB(lineTxB), .irq_n(irq_n));

  pbd_line_model line (.clock(clock), .lineTxA(lineTxA), .lineTxB(lineTxB),
    .lineRxA(lineRxA), .lineRxB(lineRxB));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clock);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'h1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'h1, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string n);
    logic [31:0] r;
    bus(a, 1'h0, 32'h0, r);
    check(n, r & m, e);
  endtask

  // command bits act on a stored rising edge, so clear them first
  task automatic cmd(input logic [31:0] b);
    wr(ADDR_CMD, 32'h0);
    wr(ADDR_CMD, b);
  endtask

  task automatic t_reset();
    rdc(ADDR_CTRL, ALL, 32'h0, "control");
    rdc(ADDR_PCFG, ALL, 32'h0, "pattern config");
    rdc(ADDR_SEED, ALL, 32'hFFFFFFFF, "seed");
    rdc(ADDR_IEN, ALL, 32'h0, "irq enable");
    rdc(8'h24, ALL, 32'h0, "unmapped");
    check("irq_n idle", {31'h0, irq_n}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_sync();
    // transmit inversion alone must keep the receiver out of sync
    logic [31:0] pc [5] = '{32'h0408, 32'h0027, 32'h4408, 32'hC408,
                            32'h0253};
    logic [31:0] sd [5] = '{32'hFFFFFFFF, 32'h00000001, 32'hFFFFFFFF,
                            32'hFFFFFFFF, 32'hFFFFFFFF};
    logic [31:0] ex [5] = '{32'h0, 32'h0, 32'h8, 32'h0, 32'h0};
    wr(ADDR_CTRL, 32'h1);
    foreach (pc[i])
    begin
      wr(ADDR_PCFG, pc[i]);
      wr(ADDR_SEED, sd[i]);
      cmd(32'h3);
      repeat (300) @(posedge clock);
      rdc(ADDR_STAT, 32'h8, ex[i], "sync state");
    end
    $display("test sync done");
  endtask

  // one error from register or pin; the pin toggles in both modes
  task automatic t_count(input logic [31:0] ctl);
    wr(ADDR_CTRL, ctl);
    cmd(32'h4);
    wr(ADDR_CMD, {28'h0, ~ctl[2], 3'h0});
    manualErrorInsertIn <= ~manualErrorInsertIn;
    repeat (100) @(posedge clock);
    rdc(ADDR_STAT, 32'h4, 32'h4, "count nonzero");
    cmd(32'h4);
    rdc(ADDR_BITCNT, ALL, 32'h70, "bit count");
    rdc(ADDR_ERRCNT, ALL, 32'h1, "error count");
    rdc(ADDR_STAT, 32'h4, 32'h0, "count cleared");
    $display("test count done");
  endtask

  task automatic t_loss();
    logic [31:0] r;
    wr(ADDR_IEN, 32'h8);
    bus(ADDR_LATCH, 1'h0, 32'h0, r);
    wr(ADDR_CTRL, 32'hB);
    repeat (200) @(posedge clock);
    rdc(ADDR_STAT, 32'h8, 32'h8, "sync lost");
    check("irq_n raised", {31'h0, irq_n}, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    repeat (200) @(posedge clock);
    rdc(ADDR_STAT, 32'h8, 32'h8, "sync held");
    rdc(ADDR_LATCH, 32'h8, 32'h8, "loss latched");
    repeat (4) @(posedge clock);
    check("irq_n after read", {31'h0, irq_n}, 32'h1);
    wr(ADDR_CTRL, 32'h41);
    cmd(32'h2);
    repeat (300) @(posedge clock);
    rdc(ADDR_STAT, 32'h8, 32'h0, "resync");
    rdc(ADDR_LATCH, 32'h8, 32'h8, "latch kept");
    check("irq_n kept", {31'h0, irq_n}, 32'h0);
    wr(ADDR_LATCH, 32'h8);
    repeat (4) @(posedge clock);
    check("irq_n after write", {31'h0, irq_n}, 32'h1);
    wr(ADDR_CTRL, 32'h9);
    repeat (200) @(posedge clock);
    rdc(ADDR_STAT, 32'h8, 32'h8, "errors keep sync off");
    wr(ADDR_CTRL, 32'h1);
    repeat (300) @(posedge clock);
    rdc(ADDR_STAT, 32'h8, 32'h0, "auto resync");
    $display("test loss done");
  endtask

  task automatic t_loop();
    logic [1:0]  r;
    logic [31:0] e;
    wr(ADDR_CTRL, 32'h300);
    for (int v = 1; v < 3; v++)
    begin
      txPosData <= v[0];
      txNegData <= v[1];
      txSysClock <= v[0];
      e = {29'h0, v[0], v[1:0]};
      repeat (8) @(posedge clock);
      check("loop", {29'h0, rxSysClock, rxNegData, rxPosData}, e);
    end
    // line rails come back out four edges after the model presents them
    @(posedge clock);
    r = {lineRxB, lineRxA};
    repeat (4) @(posedge clock);
    check("line loop", {30'h0, lineTxB, lineTxA}, {30'h0, r});
    cmd(32'h4);
    repeat (50) @(posedge clock);
    cmd(32'h4);
    rdc(ADDR_BITCNT, ALL, 32'h0, "disabled count");
    $display("test loop done");
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    t_reset();
    t_sync();
    t_count(32'h1);
    t_count(32'h5);
    t_loss();
    t_loop();
    stop_test();
  end
endmodule // tb_top
